/* File: core/psm_consts.vh */
`ifndef PSM_CONSTS_VH
`define PSM_CONSTS_VH

// ----------------------------------------
// Register offsets (indices of the port)
// ----------------------------------------
`define PSM_ADDR_CTRL 4'h0
`define PSM_ADDR_STAT 4'h1
`define PSM_ADDR_WDT 4'h2
`define PSM_ADDR_CFG 4'h3

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define PSM_CTRL_IDLE 7
`define PSM_CTRL_EN 6
`define PSM_CTRL_ROI 5
`define PSM_CTRL_DOE 4
`define PSM_CTRL_RATIO_HI 2
`define PSM_CTRL_RATIO_LO 0
`define PSM_CTRL_RST 8'h00

// ----------------------------------------
// Status and config fields
// ----------------------------------------
`define PSM_STAT_PD 0
`define PSM_STAT_TO_N 1
`define PSM_STAT_SLEEP 2
`define PSM_STAT_IDLE 3
`define PSM_CFG_WDT_SLP 0
`define PSM_CFG_ADC_DED 1

// ----------------------------------------
// Widths and timing
// ----------------------------------------
`define PSM_WDT_W 16
`define PSM_DIV_W 8
`define PSM_LFOSC_HZ 31000
`define PSM_SYS_HZ 100000000
`define PSM_ISR_VECTOR 16'h0004

`endif

/* File: core/psm_sync.v */
`timescale 1ns/1ps

// Three-stage input synchroniser with agreement on last two stages
module psm_sync (
    // Clock and reset
    input wire i_clk,
    input wire i_rst_n,
    // Asynchronous input
    input wire i_async,
    // Filtered level
    output reg o_level
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    // ----------------------------------------
    // Sync chain
    // ----------------------------------------
    // First stage feeds only the second, for metastability
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            o_level <= 1'b0;
        end else begin
            s1_q <= i_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                o_level <= s3_q;
            end
        end
    end
endmodule // psm_sync

/* File: core/psm_ctrl.v */
`timescale 1ns/1ps
`include "psm_consts.vh"

// Functional notes
// - Reduced-rate enable: one CPU cycle per N; code 100 gives 1:32.
// - Ratio code 001 gives 1:4, one active then three idle.
// - Reduced rate gates CPU and program memory only; oscillators run.
// - Peripherals keep full system clock during the unused CPU cycles.
// - Program memory prefetches the next instruction in the active cycle.
// - Interrupt entry, rate disabled: re-enter bit copies enable; full speed.
// - Enabled, recover clear: copy enable to re-enter bit; handler stays slow.
// - Enabled, recover set: copy enable to re-enter bit, then clear enable.
// - Recovering: finish multi-cycle instruction before fetching vector 0004h.
// - Prefetched instruction clearing global enable: no interrupt, still full speed.
// - Halt with idle-select clear enters sleep; set enters idle.
// - Sleep entry clears watchdog; it counts in sleep only if configured.
// - Sleep entry clears power-down flag and sets timeout flag.
// - Low, high frequency and secondary oscillators keep running in sleep.
// - Converter on dedicated osc continues; on system clock it aborts, result invalid.
// - I/O ports hold pre-halt drive in sleep unless async peripheral drives.
// - Resets other than watchdog keep working during sleep.
// - Idle halts CPU and program memory; peripheral clocks run.
// - Enabled interrupt wakes from sleep regardless of global enable.
// - Watchdog count cleared on every wake-up from sleep.
module psm_ctrl (
    // Clock and reset
    input wire i_clk,
    input wire i_rst_n,
    // Register port
    input wire [3:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    // CPU sequencer side
    input wire i_halt_exec,
    input wire i_irq_entry,
    input wire i_multi_busy,
    input wire i_prefetch_gie_clr,
    input wire i_irq_pending,
    input wire i_gie,
    input wire i_wdt_clear,
    // Asynchronous pins and peripheral state
    input wire i_wake_irq_pin,
    input wire i_ext_reset_n,
    input wire i_conv_busy,
    input wire [7:0] i_port_out,
    input wire [7:0] i_port_oe,
    input wire [7:0] i_async_drive,
    input wire [7:0] i_async_out,
    input wire [7:0] i_async_oe,
    // CPU and memory gating
    output wire o_cpu_cycle_en,
    output wire o_pfm_fetch_en,
    output reg o_vector_fetch,
    output reg [15:0] o_vector_addr,
    output reg o_irq_take,
    // Clocks and oscillators
    output wire o_periph_clk_en,
    output wire o_sys_clk_en,
    output wire o_lfosc_en,
    output wire o_hfosc_en,
    output wire o_secondary_osc_en,
    // Converter control
    output reg o_conv_abort,
    output reg o_conv_result_valid,
    // Ports held in sleep
    output reg [7:0] o_pin_out,
    output reg [7:0] o_pin_oe,
    // Watchdog and resets
    output reg o_wdt_reset,
    output wire o_reset_req
);
    // Power states
    localparam [1:0] ST_RUN = 2'b00;
    localparam [1:0] ST_SLEEP = 2'b01;
    localparam [1:0] ST_IDLE = 2'b10;

    reg [1:0] state_q;
    reg [7:0] ctrl_q;
    reg [7:0] ctrl_d;
    reg [1:0] cfg_q;
    reg pd_q;
    reg to_n_q;
    reg [`PSM_WDT_W-1:0] wdt_q;
    reg [`PSM_DIV_W-1:0] div_q;
    reg recover_q;
    reg [7:0] hold_out_q;
    reg [7:0] hold_oe_q;
    wire wake_pin;
    wire ext_rst_s;
    wire wake;
    wire active_slot;

    // Ratio code to last divider count N-1; 4-bit shift so code 111 reaches 255
    function [`PSM_DIV_W-1:0] ratio_n;
        input [2:0] code;
        begin
            ratio_n = ~(8'hFF << (code + 4'h1));
        end
    endfunction

    // Address decode shared by read and write paths
    function hit;
        input [3:0] a;
        input [3:0] b;
        begin
            hit = (a == b);
        end
    endfunction

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    psm_sync u_sync_wake (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_async(i_wake_irq_pin),
        .o_level(wake_pin)
    );

    psm_sync u_sync_rst (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_async(~i_ext_reset_n),
        .o_level(ext_rst_s)
    );

    // External reset honoured in every state
    assign o_reset_req = ext_rst_s;

    // Wake on enabled interrupt, global enable ignored
    assign wake = i_irq_pending | wake_pin;

    // ----------------------------------------
    // Rate divider
    // ----------------------------------------
    // One slot per N cycles when enabled
    assign active_slot = ~ctrl_q[`PSM_CTRL_EN] | (div_q == 8'h00);

    // Counter wraps at N-1, code 001 gives four
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_q <= 8'h00;
        end else if (!ctrl_q[`PSM_CTRL_EN] || state_q != ST_RUN) begin
            div_q <= 8'h00;
        end else if (div_q >= ratio_n(ctrl_q[`PSM_CTRL_RATIO_HI:`PSM_CTRL_RATIO_LO])) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    // Gate only CPU and memory; idle stops both
    assign o_cpu_cycle_en = (state_q == ST_RUN) & active_slot;
    // Prefetch follows the active CPU slot
    assign o_pfm_fetch_en = (state_q == ST_RUN) & active_slot;
    // Peripherals run in run and idle at full rate
    assign o_periph_clk_en = (state_q != ST_SLEEP);
    // System clock stopped in full sleep
    assign o_sys_clk_en = (state_q != ST_SLEEP);
    assign o_lfosc_en = 1'b1;
    assign o_hfosc_en = 1'b1;
    assign o_secondary_osc_en = 1'b1;

    // ----------------------------------------
    // Control register and interrupt entry
    // ----------------------------------------
    // Software write first, then hardware update overrides its fields
    always @* begin
        ctrl_d = ctrl_q;
        if (i_wr && hit(i_addr, `PSM_ADDR_CTRL)) begin
            // Re-enter bit stays writable in handler
            ctrl_d = {i_wdata[7:4], 1'b0, i_wdata[2:0]};
        end
        if (i_irq_entry) begin
            ctrl_d[`PSM_CTRL_DOE] = ctrl_q[`PSM_CTRL_EN];
            if (ctrl_q[`PSM_CTRL_ROI]) begin
                ctrl_d[`PSM_CTRL_EN] = 1'b0;
            end
        end
        // Global enable cleared by prefetch still drops rate
        if (recover_q && i_prefetch_gie_clr) begin
            ctrl_d[`PSM_CTRL_EN] = 1'b0;
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_q <= `PSM_CTRL_RST;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // ----------------------------------------
    // Vector fetch after recovery
    // ----------------------------------------
    // Recovery waits on busy so a multi-cycle op is never split
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            recover_q <= 1'b0;
            o_vector_fetch <= 1'b0;
            o_vector_addr <= 16'h0000;
            o_irq_take <= 1'b0;
        end else begin
            o_vector_fetch <= 1'b0;
            o_irq_take <= 1'b0;
            if (i_irq_pending && ctrl_q[`PSM_CTRL_EN] && ctrl_q[`PSM_CTRL_ROI]
                && state_q == ST_RUN && !o_irq_take && !i_irq_entry) begin // One take per entry
                recover_q <= 1'b1;
            end
            // Vector only after multi-cycle op done
            if (recover_q && !i_multi_busy) begin
                recover_q <= 1'b0;
                // No vector when global enable drops
                if (i_gie && !i_prefetch_gie_clr) begin
                    o_vector_fetch <= 1'b1;
                    o_vector_addr <= `PSM_ISR_VECTOR;
                    o_irq_take <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // Power state machine
    // ----------------------------------------
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= ST_RUN;
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (i_halt_exec) begin
                        state_q <= ctrl_q[`PSM_CTRL_IDLE] ? ST_IDLE : ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (wake) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_IDLE: begin
                    if (wake) begin
                        state_q <= ST_RUN;
                    end
                end
                default: begin
                    state_q <= ST_RUN;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Status flags and watchdog
    // ----------------------------------------
    // Watchdog stands still in sleep unless configured to run
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pd_q <= 1'b1;
            to_n_q <= 1'b1;
            wdt_q <= 16'h0000;
            o_wdt_reset <= 1'b0;
        end else begin
            o_wdt_reset <= 1'b0;
            if (state_q == ST_RUN && i_halt_exec && !ctrl_q[`PSM_CTRL_IDLE]) begin
                pd_q <= 1'b0;
                to_n_q <= 1'b1;
                wdt_q <= 16'h0000;
            end else if (state_q == ST_SLEEP && wake) begin
                wdt_q <= 16'h0000;
            end else if (i_wdt_clear) begin
                wdt_q <= 16'h0000;
            end else if (state_q != ST_SLEEP || cfg_q[`PSM_CFG_WDT_SLP]) begin
                // Count in sleep only when enabled
                if (wdt_q == 16'hFFFF) begin
                    // Watchdog is the one reset sleep suppresses
                    o_wdt_reset <= (state_q == ST_RUN);
                    to_n_q <= (state_q == ST_RUN) ? 1'b0 : to_n_q;
                    wdt_q <= 16'h0000;
                end else begin
                    wdt_q <= wdt_q + 16'h0001;
                end
            end
        end
    end

    // ----------------------------------------
    // Converter and ports in sleep
    // ----------------------------------------
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_conv_abort <= 1'b0;
            o_conv_result_valid <= 1'b1;
            hold_out_q <= 8'h00;
            hold_oe_q <= 8'h00;
        end else begin
            o_conv_abort <= 1'b0;
            if (state_q == ST_RUN && i_halt_exec && !ctrl_q[`PSM_CTRL_IDLE]) begin
                if (i_conv_busy && !cfg_q[`PSM_CFG_ADC_DED]) begin
                    o_conv_abort <= 1'b1;
                    o_conv_result_valid <= 1'b0;
                end
                hold_out_q <= i_port_out;
                hold_oe_q <= i_port_oe;
            end else if (i_conv_busy && state_q == ST_RUN) begin
                o_conv_result_valid <= 1'b1;
            end
        end
    end

    // Async peripheral overrides held value per pin
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pin_out <= 8'h00;
            o_pin_oe <= 8'h00;
        end else if (state_q == ST_SLEEP) begin
            o_pin_out <= (hold_out_q & ~i_async_drive) | (i_async_out & i_async_drive);
            o_pin_oe <= (hold_oe_q & ~i_async_drive) | (i_async_oe & i_async_drive);
        end else begin
            o_pin_out <= i_port_out;
            o_pin_oe <= i_port_oe;
        end
    end

    // ----------------------------------------
    // Config writes and read port
    // ----------------------------------------
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_q <= 2'b00;
            o_rdata <= 8'h00;
        end else begin
            if (i_wr && hit(i_addr, `PSM_ADDR_CFG)) begin
                cfg_q <= i_wdata[1:0];
            end
            o_rdata <= 8'h00;
            if (i_rd) begin
                if (hit(i_addr, `PSM_ADDR_CTRL)) begin
                    o_rdata <= ctrl_q;
                end else if (hit(i_addr, `PSM_ADDR_STAT)) begin
                    o_rdata <= {4'h0, state_q == ST_IDLE, state_q == ST_SLEEP, to_n_q, pd_q};
                end else if (hit(i_addr, `PSM_ADDR_WDT)) begin
                    o_rdata <= wdt_q[15:8];
                end else if (hit(i_addr, `PSM_ADDR_CFG)) begin
                    o_rdata <= {6'h00, cfg_q};
                end
            end
        end
    end
endmodule // psm_ctrl

/* File: verif/psm_cpu_model.sv */
`timescale 1ns/1ps

// ----------------------------------------
// Sequencer stand-in on the far side
// ----------------------------------------
module psm_cpu_model (
    // Clock and reset
    input wire i_clk,
    input wire i_rst_n,
    // From the block
    input wire i_cycle_en,
    input wire i_fetch_en,
    input wire i_irq_take,
    // From the bench, a forced handler entry
    input wire i_kick,
    // Back to block and bench
    output reg o_irq_entry,
    output reg [15:0] o_fetch_cnt
);
    // Enter the handler one cycle after a take, as a real core would
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq_entry <= 1'b0;
            o_fetch_cnt <= 16'h0000;
        end else begin
            o_irq_entry <= i_irq_take | i_kick;
            if (i_fetch_en && i_cycle_en) begin
                o_fetch_cnt <= o_fetch_cnt + 16'h0001;
            end
        end
    end
endmodule // psm_cpu_model

/* File: verif/psm_ctrl_assertions.sv */
`timescale 1ns/1ps

// ----------------------------------------
// Port checker
// ----------------------------------------
module psm_ctrl_chk (
    // Clock, reset, register writes
    input wire i_clk,
    input wire i_rst_n,
    input wire [3:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    // Sequencer and pins
    input wire i_halt_exec,
    input wire i_multi_busy,
    input wire i_prefetch_gie_clr,
    input wire i_irq_pending,
    input wire i_conv_busy,
    input wire i_wake_irq_pin,
    input wire i_ext_reset_n,
    // Watched outputs
    input wire o_cpu_cycle_en,
    input wire o_pfm_fetch_en,
    input wire o_vector_fetch,
    input wire [15:0] o_vector_addr,
    input wire o_irq_take,
    input wire o_periph_clk_en,
    input wire o_sys_clk_en,
    input wire o_lfosc_en,
    input wire o_hfosc_en,
    input wire o_secondary_osc_en,
    input wire o_conv_abort,
    input wire o_reset_req
);
    reg idle_q;
    reg ded_q;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    // Shadow of idle select and converter clock; hardware never alters them
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            idle_q <= 1'b0;
            ded_q <= 1'b0;
        end else if (i_wr && i_addr == 4'h0) begin
            idle_q <= i_wdata[7];
        end else if (i_wr && i_addr == 4'h3) begin
            ded_q <= i_wdata[1];
        end
    end

    a_fetch_in_slot: assert property (o_pfm_fetch_en == o_cpu_cycle_en)
        else $error("fetch enable off the cpu slot");
    a_osc_kept_on: assert property (o_lfosc_en && o_hfosc_en && o_secondary_osc_en)
        else $error("oscillator stopped");
    a_periph_clk_runs: assert property (o_sys_clk_en |-> o_periph_clk_en)
        else $error("peripheral clock gated");
    a_sleep_no_cpu: assert property (!o_sys_clk_en |-> !o_cpu_cycle_en)
        else $error("cpu slot with system clock off");
    a_halt_to_sleep: assert property (i_halt_exec && !idle_q && !i_irq_pending |=> !o_sys_clk_en)
        else $error("halt did not stop the clock");
    a_halt_to_idle: assert property (i_halt_exec && idle_q && !i_irq_pending |=>
        o_sys_clk_en && !o_cpu_cycle_en)
        else $error("idle entry wrong");
    a_vector_after_multi: assert property (o_vector_fetch |->
        !$past(i_multi_busy) && o_vector_addr == 16'h0004)
        else $error("vector fetch early or wrong address");
    a_gie_clr_blocks: assert property (o_irq_take |-> !$past(i_prefetch_gie_clr))
        else $error("interrupt taken after global enable cleared");
    a_conv_abandon: assert property (i_halt_exec && !idle_q && !ded_q && i_conv_busy &&
        !i_irq_pending |-> ##[1:3] o_conv_abort)
        else $error("conversion not abandoned");
    a_wake_clk_on: assert property ($rose(i_wake_irq_pin) && !o_sys_clk_en |->
        ##[1:8] o_sys_clk_en)
        else $error("no wake from sleep");
    a_ext_reset_sleep: assert property ($fell(i_ext_reset_n) |-> ##[1:6] o_reset_req)
        else $error("external reset lost");

    c_sleep: cover property (i_halt_exec && !idle_q ##1 !o_sys_clk_en);
    c_vector: cover property (o_vector_fetch);
    c_abort: cover property (o_conv_abort);
endmodule // psm_ctrl_chk

bind psm_ctrl psm_ctrl_chk psm_ctrl_chk_i (.*);

/* File: verif/tb_top.sv */
`timescale 1ns/1ps

module tb_top;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    reg i_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, kick = 1'b0;
    reg i_halt_exec = 1'b0, i_multi_busy = 1'b0, i_prefetch_gie_clr = 1'b0;
    reg i_irq_pending = 1'b0, i_gie = 1'b0, i_wdt_clear = 1'b0, i_wake_irq_pin = 1'b0;
    reg i_ext_reset_n = 1'b1, i_conv_busy = 1'b0;
    reg [3:0] i_addr = 4'h0;
    reg [7:0] i_wdata = 8'h00, i_port_out = 8'h00, i_port_oe = 8'h00;
    reg [7:0] i_async_drive = 8'h00, i_async_out = 8'h00, i_async_oe = 8'h00, e;
    reg [15:0] f0;
    wire [7:0] o_rdata, o_pin_out, o_pin_oe;
    wire [15:0] o_vector_addr, fetch_cnt;
    wire o_cpu_cycle_en, o_pfm_fetch_en, o_vector_fetch, o_irq_take, i_irq_entry;
    wire o_periph_clk_en, o_sys_clk_en, o_lfosc_en, o_hfosc_en, o_secondary_osc_en;
    wire o_conv_abort, o_conv_result_valid, o_wdt_reset, o_reset_req;
    integer n_mismatch = 0, tests_run = 0, n_vf = 0, n_abort = 0, k, cnt;

    psm_ctrl psm_ctrl_i (.*);
    psm_cpu_model psm_cpu_model_i (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_cycle_en(o_cpu_cycle_en),
        .i_fetch_en(o_pfm_fetch_en),
        .i_irq_take(o_irq_take),
        .i_kick(kick),
        .o_irq_entry(i_irq_entry),
        .o_fetch_cnt(fetch_cnt)
    );

    always #5 i_clk = ~i_clk;

    // Pulse tallies on the falling edge, clear of the launch edge
    always @(negedge i_clk) begin
        n_vf = n_vf + o_vector_fetch;
        n_abort = n_abort + o_conv_abort;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task give_verdict;
        begin
            $display("compares %0d mismatches %0d", tests_run, n_mismatch);
            if (n_mismatch == 0 && tests_run > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask

    task chk(input [15:0] got, input [15:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("[ERR] %0t got %h want %h", $time, got, exp);
            end
        end
    endtask

    task wr_reg(input [3:0] a, input [7:0] d);
        begin
            @(posedge i_clk);
            i_addr <= a;
            i_wdata <= d;
            i_wr <= 1'b1;
            @(posedge i_clk);
            i_wr <= 1'b0;
        end
    endtask

    // Read data stand only in the cycle after the strobe
    task rd_chk(input [3:0] a, input [7:0] x);
        begin
            @(posedge i_clk);
            i_addr <= a;
            i_rd <= 1'b1;
            @(posedge i_clk);
            i_rd <= 1'b0;
            #1;
            chk({8'h00, o_rdata}, {8'h00, x});
        end
    endtask

    // Bounded wait: 0 vector pulse, 1 cpu slot, 2 reset request
    task wait_for(input integer sel, input integer lim);
        begin
            cnt = 0;
            while (cnt < lim && !(sel == 0 ? n_vf > 0 : sel == 1 ?
                    o_cpu_cycle_en === 1'b1 : o_reset_req === 1'b1)) begin
                @(posedge i_clk);
                #1;
                cnt = cnt + 1;
            end
            if (cnt >= lim) begin
                n_mismatch = n_mismatch + 1;
                $display("[ERR] %0t wait ran out", $time);
                give_verdict;
            end
        end
    endtask

    task count_slots(input integer m);
        begin
            k = 0;
            cnt = 0;
            f0 = fetch_cnt;
            repeat (m) begin
                @(posedge i_clk);
                #1;
                k = k + o_cpu_cycle_en;
                cnt = cnt + o_periph_clk_en;
            end
        end
    endtask

    task halt;
        begin
            @(posedge i_clk);
            i_halt_exec <= 1'b1;
            @(posedge i_clk);
            i_halt_exec <= 1'b0;
            #1;
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset_vals;
        begin
            rd_chk(4'h0, 8'h00);
            rd_chk(4'h1, 8'h03);
            wr_reg(4'h7, 8'hFF);
            rd_chk(4'h7, 8'h00);
            wr_reg(4'h0, 8'h08);
            rd_chk(4'h0, 8'h00);
            $display("reset values done");
        end
    endtask

    // Every ratio code; windows are whole multiples of the period
    task t_ratio;
        integer c;
        begin
            for (c = 0; c < 8; c = c + 1) begin
                wr_reg(4'h0, {5'h08, c[2:0]});
                repeat (4 << c) @(posedge i_clk);
                count_slots(16 << c);
                chk(k[15:0], 16'h0008);
                chk(fetch_cnt - f0, 16'h0008);
                chk(cnt[15:0], 16'h0010 << c);
            end
            wr_reg(4'h0, 8'h00);
            count_slots(16);
            chk(k[15:0], 16'h0010);
            $display("ratio test done");
        end
    endtask

    task t_isr;
        integer c;
        begin
            for (c = 0; c < 4; c = c + 1) begin
                wr_reg(4'h0, {1'b0, c[1], c[0], 5'h01});
                kick <= 1'b1;
                @(posedge i_clk);
                kick <= 1'b0;
                @(posedge i_clk);
                e = {1'b0, c[1] & ~c[0], c[0], c[1], 4'h1};
                rd_chk(4'h0, e);
                wr_reg(4'h0, e ^ 8'h10);
                rd_chk(4'h0, e ^ 8'h10);
            end
            wr_reg(4'h0, 8'h00);
            $display("handler entry done");
        end
    endtask

    task t_recover;
        begin
            @(posedge i_clk);
            i_gie <= 1'b1;
            i_multi_busy <= 1'b1;
            wr_reg(4'h0, 8'h61);
            i_irq_pending <= 1'b1;
            n_vf = 0;
            repeat (12) @(posedge i_clk);
            i_multi_busy <= 1'b0;
            #1;
            chk(n_vf[15:0], 16'h0000);
            wait_for(0, 12);
            @(posedge i_clk);
            i_irq_pending <= 1'b0;
            rd_chk(4'h0, 8'h31);
            count_slots(8);
            chk(k[15:0], 16'h0008);
            chk(n_vf[15:0], 16'h0001);
            chk(o_vector_addr, 16'h0004);
            $display("recover done");
        end
    endtask

    task t_gie_clr;
        begin
            @(posedge i_clk);
            i_prefetch_gie_clr <= 1'b1;
            wr_reg(4'h0, 8'h61);
            i_irq_pending <= 1'b1;
            n_vf = 0;
            repeat (10) @(posedge i_clk);
            i_irq_pending <= 1'b0;
            i_prefetch_gie_clr <= 1'b0;
            i_gie <= 1'b0;
            #1;
            chk(n_vf[15:0], 16'h0000);
            rd_chk(4'h0, 8'h21);
            count_slots(8);
            chk(k[15:0], 16'h0008);
            wr_reg(4'h0, 8'h00);
            $display("global enable clear done");
        end
    endtask

    task t_sleep(input ded, input wslp);
        begin
            wr_reg(4'h3, {6'h00, ded, wslp});
            i_port_out <= 8'hA5;
            i_port_oe <= 8'h0F;
            i_conv_busy <= 1'b1;
            repeat (3) @(posedge i_clk);
            n_abort = 0;
            halt;
            chk({o_sys_clk_en, o_cpu_cycle_en}, 16'h0000);
            chk({o_lfosc_en, o_hfosc_en, o_secondary_osc_en}, 16'h0007);
            rd_chk(4'h1, 8'h06);
            rd_chk(4'h2, 8'h00);
            chk(n_abort[15:0], {15'h0000, ~ded});
            if (!ded) chk(o_conv_result_valid, 16'h0000);
            @(posedge i_clk);
            i_port_out <= 8'h3C;
            i_async_drive <= 8'h80;
            i_async_oe <= 8'h80;
            repeat (3) @(posedge i_clk);
            #1;
            chk({o_pin_oe, o_pin_out}, 16'h8F25);
            repeat (296) @(posedge i_clk);
            rd_chk(4'h2, {7'h00, wslp});
            @(posedge i_clk);
            i_wake_irq_pin <= 1'b1;
            wait_for(1, 10);
            @(posedge i_clk);
            i_wake_irq_pin <= 1'b0;
            i_conv_busy <= 1'b0;
            i_async_drive <= 8'h00;
            i_async_oe <= 8'h00;
            rd_chk(4'h2, 8'h00);
            rd_chk(4'h1, 8'h02);
            $display("sleep done");
        end
    endtask

    task t_idle;
        begin
            wr_reg(4'h0, 8'h80);
            halt;
            chk({o_cpu_cycle_en, o_pfm_fetch_en, o_sys_clk_en, o_periph_clk_en},
                16'h0003);
            rd_chk(4'h1, 8'h0A);
            @(posedge i_clk);
            i_wake_irq_pin <= 1'b1;
            wait_for(1, 10);
            @(posedge i_clk);
            i_wake_irq_pin <= 1'b0;
            rd_chk(4'h0, 8'h80);
            wr_reg(4'h0, 8'h00);
            $display("idle done");
        end
    endtask

    task t_reset_src;
        begin
            halt;
            @(posedge i_clk);
            i_ext_reset_n <= 1'b0;
            wait_for(2, 10);
            @(posedge i_clk);
            i_ext_reset_n <= 1'b1;
            i_rst_n <= 1'b0;
            repeat (4) @(posedge i_clk);
            i_rst_n <= 1'b1;
            rd_chk(4'h1, 8'h03);
            repeat (65540) @(posedge i_clk);
            rd_chk(4'h1, 8'h01);
            $display("reset in sleep done");
        end
    endtask

    // Main sequence
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_reset_vals;
        t_ratio;
        t_isr;
        t_recover;
        t_gie_clr;
        t_sleep(1'b0, 1'b1);
        t_sleep(1'b1, 1'b0);
        t_idle;
        t_reset_src;
        give_verdict;
    end
endmodule // tb_top
